// [core/fscp_guard.sv]
// Security gate on flash read data.
// Assumes the security bit is the loaded working option bit.
`timescale 1ns/100ps
`default_nettype none
module fscp_guard
(
   input wire logic secured_in,
   input wire logic debug_in,
   input wire logic pin_en_in,
   input wire logic is_flash_in,
   input wire logic [7:0] data_in,
   output logic blocked_out,
   output logic [7:0] data_out
);
   // Only flash is protected; other targets pass untouched
   assign blocked_out = secured_in && is_flash_in &&
      (debug_in || pin_en_in); // R1 R2
   assign data_out = blocked_out ? 8'h00 : data_in; // R1
endmodule : fscp_guard
`default_nettype wire

// [core/fscp_map.svh]
// Offsets, field positions, reset values and encodings of the flash
// security, program/erase control and paging block.
// Assumes a byte-wide register port and a 14-bit CPU address space.
`ifndef FSCP_MAP_SVH
`define FSCP_MAP_SVH

`define FSCP_ADDR_W 14
`define FSCP_FLASH_OPTION_WORKING_OFS 14'h023C
`define FSCP_FLASH_PROGRAM_ERASE_CONTROL_OFS 14'h023D
`define FSCP_FLASH_OPTION_NONVOLATILE_OFS 14'h3FFC
`define FSCP_PAGING_WINDOW_SELECTOR_OFS 14'h001F

`define FSCP_SECURITY_DISENGAGE_BIT_BIT 0
`define FSCP_PGM_BIT 0
`define FSCP_MASS_BIT 2
`define FSCP_HIGH_VOLTAGE_ENABLE_BIT 3

`define FSCP_PAGING_WINDOW_SELECTOR_RST 8'h00
`define FSCP_FLASH_PROGRAM_ERASE_CONTROL_RST 8'h00

`define FSCP_WIN_LO 14'h00C0
`define FSCP_WIN_HI 14'h00FF
`define FSCP_FLASH_LO 14'h2000
`define FSCP_PAGE_FLASH_MIN 8'h80
`define FSCP_PAGE_HREG_LO 8'h08
`define FSCP_PAGE_HREG_HI 8'h09

`endif

// [core/fscp_pager.sv]
// Paging window address translation.
// Assumes an access address and the current page selector value.
`timescale 1ns/100ps
`default_nettype none
`include "fscp_map.svh"
module fscp_pager
(
   input wire logic [13:0] addr_in,
   input wire logic [7:0] page_in,
   output logic [13:0] phys_addr_out,
   output fscp_pkg::fscp_target_t target_out
);
   import fscp_pkg::*;
   logic in_win;
   assign in_win = (addr_in >= `FSCP_WIN_LO) && (addr_in <= `FSCP_WIN_HI);
   // Window offset is the low six bits, page gives bits 13:6
   assign phys_addr_out = in_win ? {page_in, addr_in[5:0]} : addr_in; // R14 R15
   always_comb
   begin
      if (phys_addr_out >= `FSCP_FLASH_LO)
         target_out = FSCP_TGT_FLASH; // R16
      else if (in_win && (page_in >= `FSCP_PAGE_HREG_LO) &&
         (page_in <= `FSCP_PAGE_HREG_HI))
         target_out = FSCP_TGT_HREG; // R16
      else if (in_win && (page_in > 8'h02))
         target_out = FSCP_TGT_NONE; // R16
      else if (in_win)
         target_out = FSCP_TGT_LOW; // R16
      else if (!in_win && (addr_in >= 14'h0200) && (addr_in <= 14'h027F))
         target_out = FSCP_TGT_HREG;
      else if (!in_win && (addr_in < 14'h0100))
         target_out = FSCP_TGT_LOW;
      else
         target_out = FSCP_TGT_NONE;
   end
endmodule : fscp_pager
`default_nettype wire

// [core/fscp_pkg.sv]
// Types shared by the flash security, control and paging block.
// Assumes the _map header supplies all numeric constants.
package fscp_pkg;
   typedef enum logic [1:0]
   {
      FSCP_TGT_NONE = 2'b00,
      FSCP_TGT_FLASH = 2'b01,
      FSCP_TGT_HREG = 2'b10,
      FSCP_TGT_LOW = 2'b11
   } fscp_target_t;

   typedef struct packed
   {
      logic [13:0] addr;
      logic rd;
      logic wr;
      logic debug;
   } fscp_access_t;

   typedef struct packed
   {
      logic high_voltage_enable;
      logic mass;
      logic program_select;
   } fscp_flash_program_erase_control_t;
endpackage : fscp_pkg

// [core/fscp_top.sv]
// Flash security, program/erase control and direct-page paging window.
// Assumes a CPU/debug register port, a flash array beside it, and that
// the reset line is asserted on every power-on, pin or internal reset.
// Behaviour
// R1: Secured: debug-path or pin-enabled flash reads blocked, return zero.
// R2: RAM, registers and debug controller stay reachable when secured.
// R3: Every reset copies the nonvolatile option byte into working option.
// R4: Option bit 0 clear engages security, set disengages it.
// R5: New security setting takes effect only after the next reset.
// R6: Host removes security by mass erase then pin or power-on reset.
// R7: Working option bits 7 to 1 always read zero.
// R8: Writes to working option register have no effect.
// R9: Normal-mode reset while secured clears debug pin enable, blocks debug.
// R10: High voltage enable sets only with program or mass and sequence.
// R11: Control bit 2 is read/write mass erase select.
// R12: Program select bit 0 interlocked with mass; never both one.
// R13: While secured, writes to program select are ignored.
// R14: Page selector supplies address bits 6 through 13 in window.
// R15: Window occupies C0 to FF; page picks the 64-byte block.
// R16: Pages 80-FF map flash, 08-09 high registers, others unavailable; the code maps pages 00-02 to low memory.
// R17: Programmer writes flash one aligned 64-byte row at a time.
// R18: Mass erase: select, write flash, wait, HV, clear mass, clear HV.
// R19: Program, mass and high voltage enables reset to zero.
`timescale 1ns/100ps
`default_nettype none
`include "fscp_map.svh"
module fscp_top
(
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire logic CE_IN,
   input wire logic MODE_SELECT_PIN_IN,
   input wire logic [13:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   input wire logic DEBUG_IN,
   input wire logic [7:0] FLASH_OPTION_NONVOLATILE_DATA_IN,
   input wire logic [7:0] MEM_RDATA_IN,
   output logic [7:0] RDATA_OUT,
   output logic [13:0] MEM_ADDR_OUT,
   output logic MEM_WR_OUT,
   output logic MEM_RD_OUT,
   output logic DEBUG_PIN_ENABLE_OUT,
   output logic DEBUG_BLOCKED_OUT,
   output logic SECURED_OUT,
   output logic HIGH_VOLTAGE_ENABLE_OUT,
   output logic MASS_ERASE_SELECT_OUT,
   output logic PROGRAM_SELECT_OUT,
   output logic ACCESS_BLOCKED_OUT
);
   import fscp_pkg::*;

   typedef enum logic [1:0]
   {
      FSCP_ST_LOAD = 2'b00,
      FSCP_ST_RUN = 2'b01
   } fscp_state_t;

   fscp_state_t state_q;
   logic [7:0] opt_q;
   logic [7:0] page_q;
   fscp_flash_program_erase_control_t flash_program_erase_control_q;
   fscp_flash_program_erase_control_t flash_program_erase_control_d;
   logic armed_q;
   logic pin_en_q;
   logic dbg_block_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   fscp_access_t acc;
   fscp_target_t target;
   logic [13:0] phys_addr;
   logic secured;
   logic blocked;
   logic [7:0] flash_data;
   logic wr_flash_program_erase_control;
   logic wr_page;
   logic dbg_refused;

   assign acc = '{addr: ADDR_IN, rd: RD_IN, wr: WR_IN, debug: DEBUG_IN};
   assign secured = (state_q == FSCP_ST_RUN) &&
      !opt_q[`FSCP_SECURITY_DISENGAGE_BIT_BIT]; // R4
   // Debug traffic refused entirely after a secured normal-mode boot
   assign dbg_refused = acc.debug && dbg_block_q; // R9

   fscp_pager u_pager
   (
      .addr_in(acc.addr),
      .page_in(page_q),
      .phys_addr_out(phys_addr),
      .target_out(target)
   );

   fscp_guard u_guard
   (
      .secured_in(secured),
      .debug_in(acc.debug),
      .pin_en_in(pin_en_q),
      .is_flash_in(target == FSCP_TGT_FLASH),
      .data_in(MEM_RDATA_IN),
      .blocked_out(blocked),
      .data_out(flash_data)
   );

   // Option load on the first enabled cycle after reset release
   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         state_q <= FSCP_ST_LOAD;
      else if (CE_IN)
      begin
         case (state_q)
            FSCP_ST_LOAD: state_q <= FSCP_ST_RUN;
            FSCP_ST_RUN: state_q <= FSCP_ST_RUN;
            default: state_q <= FSCP_ST_LOAD;
         endcase
      end
   end

   // Loaded only at reset: reprogramming acts after the next reset
   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         opt_q <= 8'h00;
      else if (CE_IN && (state_q == FSCP_ST_LOAD))
         opt_q <= {7'h00, FLASH_OPTION_NONVOLATILE_DATA_IN[`FSCP_SECURITY_DISENGAGE_BIT_BIT]}; // R3 R5 R7 R8
   end

   // Debug pin enable follows mode pin and security at load
   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         pin_en_q <= 1'b0;
         dbg_block_q <= 1'b1;
      end
      else if (CE_IN && (state_q == FSCP_ST_LOAD))
      begin
         if (MODE_SELECT_PIN_IN && !FLASH_OPTION_NONVOLATILE_DATA_IN[`FSCP_SECURITY_DISENGAGE_BIT_BIT])
         begin
            pin_en_q <= 1'b0; // R9
            dbg_block_q <= 1'b1; // R9
         end
         else
         begin
            pin_en_q <= 1'b1;
            dbg_block_q <= 1'b0;
         end
      end
   end

   assign wr_flash_program_erase_control = CE_IN && acc.wr && !dbg_refused &&
      (phys_addr == `FSCP_FLASH_PROGRAM_ERASE_CONTROL_OFS);
   assign wr_page = CE_IN && acc.wr && !dbg_refused &&
      (acc.addr == `FSCP_PAGING_WINDOW_SELECTOR_OFS);

   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         page_q <= `FSCP_PAGING_WINDOW_SELECTOR_RST;
      else if (wr_page)
         page_q <= WDATA_IN; // R14
   end

   // A flash write while a mode is selected arms the high voltage step
   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         armed_q <= 1'b0;
      else if (CE_IN)
      begin
         if (!flash_program_erase_control_q.program_select && !flash_program_erase_control_q.mass)
            armed_q <= 1'b0;
         else if (acc.wr && !dbg_refused && (target == FSCP_TGT_FLASH))
            armed_q <= 1'b1; // R10 R18
      end
   end

   always_comb
   begin
      logic w_pgm;
      logic w_mass;
      logic w_high_voltage_enable;
      w_pgm = WDATA_IN[`FSCP_PGM_BIT];
      w_mass = WDATA_IN[`FSCP_MASS_BIT];
      w_high_voltage_enable = WDATA_IN[`FSCP_HIGH_VOLTAGE_ENABLE_BIT];
      flash_program_erase_control_d = flash_program_erase_control_q;
      if (wr_flash_program_erase_control)
      begin
         flash_program_erase_control_d.mass = w_mass; // R11
         if (w_mass && (flash_program_erase_control_q.program_select || w_pgm))
            flash_program_erase_control_d.mass = flash_program_erase_control_q.mass; // R12
         if (!secured) // R13
         begin
            flash_program_erase_control_d.program_select = w_pgm;
            if (w_pgm && (flash_program_erase_control_q.mass || w_mass))
               flash_program_erase_control_d.program_select = flash_program_erase_control_q.program_select; // R12
         end
         if (!w_high_voltage_enable)
            flash_program_erase_control_d.high_voltage_enable = 1'b0;
         else if ((flash_program_erase_control_q.program_select || flash_program_erase_control_q.mass) && armed_q)
            flash_program_erase_control_d.high_voltage_enable = 1'b1; // R10
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         flash_program_erase_control_q <= '{high_voltage_enable: 1'b0, mass: 1'b0, program_select: 1'b0}; // R19
      else if (CE_IN)
         flash_program_erase_control_q <= flash_program_erase_control_d;
   end

   // Register reads answer in the next cycle only
   always_comb
   begin
      rdata_d = 8'h00;
      if (acc.rd && !dbg_refused)
      begin
         if (phys_addr == `FSCP_FLASH_OPTION_WORKING_OFS)
            rdata_d = opt_q; // R7 R8
         else if (phys_addr == `FSCP_FLASH_PROGRAM_ERASE_CONTROL_OFS)
            rdata_d = {4'h0, flash_program_erase_control_q.high_voltage_enable, flash_program_erase_control_q.mass, 1'b0, flash_program_erase_control_q.program_select};
         else if (acc.addr == `FSCP_PAGING_WINDOW_SELECTOR_OFS)
            rdata_d = page_q;
         else if (target == FSCP_TGT_FLASH)
            rdata_d = flash_data; // R1
         else if (target != FSCP_TGT_NONE)
            rdata_d = MEM_RDATA_IN; // R2
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         rdata_q <= 8'h00;
      else if (CE_IN)
         rdata_q <= rdata_d;
   end

   // Memory side sees the translated address combinationally
   assign MEM_ADDR_OUT = phys_addr; // R15
   assign MEM_RD_OUT = CE_IN && acc.rd && !dbg_refused && !blocked &&
      (target != FSCP_TGT_NONE);
   assign MEM_WR_OUT = CE_IN && acc.wr && !dbg_refused &&
      (target != FSCP_TGT_NONE) && !(secured && acc.debug &&
      (target == FSCP_TGT_FLASH));
   assign ACCESS_BLOCKED_OUT = (acc.rd || acc.wr) && (blocked || dbg_refused);
   assign RDATA_OUT = rdata_q;
   assign DEBUG_PIN_ENABLE_OUT = pin_en_q;
   assign DEBUG_BLOCKED_OUT = dbg_block_q;
   assign SECURED_OUT = secured;
   assign HIGH_VOLTAGE_ENABLE_OUT = flash_program_erase_control_q.high_voltage_enable;
   assign MASS_ERASE_SELECT_OUT = flash_program_erase_control_q.mass;
   assign PROGRAM_SELECT_OUT = flash_program_erase_control_q.program_select;
endmodule : fscp_top
`default_nettype wire

// [testbench/fscp_mem_model.sv]
// Memory array beside the block: answers in the cycle of the strobe.
// Assumes the physical address and read pulse come straight from it.
`timescale 1ns/100ps
`default_nettype none
module fscp_mem_model
(
   input wire logic clk_in,
   input wire logic [13:0] addr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out
);
   import fscp_pkg::*;
   logic [7:0] idle_q = 8'h00;
   // Moving pattern off-strobe so a stale capture cannot pass
   always_ff @(posedge clk_in)
      idle_q <= idle_q + 8'h01;
   assign rdata_out = rd_in ? (addr_in[7:0] ^ 8'h3C) : ~idle_q;
endmodule : fscp_mem_model
`default_nettype wire

// [testbench/fscp_top_asserts.sv]
// Port-level checks for the flash security, control and paging block.
// Assumes one clock and bind onto every fscp_top instance.
`timescale 1ns/100ps
`default_nettype none
`include "fscp_map.svh"
module fscp_top_asserts
(
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire logic CE_IN,
   input wire logic [13:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   input wire logic DEBUG_IN,
   input wire logic [7:0] RDATA_OUT,
   input wire logic MEM_RD_OUT,
   input wire logic MEM_WR_OUT,
   input wire logic DEBUG_PIN_ENABLE_OUT,
   input wire logic DEBUG_BLOCKED_OUT,
   input wire logic SECURED_OUT,
   input wire logic HIGH_VOLTAGE_ENABLE_OUT,
   input wire logic MASS_ERASE_SELECT_OUT,
   input wire logic PROGRAM_SELECT_OUT,
   input wire logic ACCESS_BLOCKED_OUT
);
   import fscp_pkg::*;
   logic up_q;
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   // Skips the load edge, where the option bit may legally move
   always_ff @(posedge CLK_IN or negedge RST_N_IN)
      if (!RST_N_IN) up_q <= 1'b0;
      else if (CE_IN) up_q <= 1'b1;
   property p_blk;
      ACCESS_BLOCKED_OUT |-> !MEM_RD_OUT ##1 RDATA_OUT == 8'h00;
   endproperty
   a_blk: assert property (p_blk) else $error("refused access leaked");
   property p_opt;
      CE_IN && RD_IN && ADDR_IN == `FSCP_FLASH_OPTION_WORKING_OFS
         |=> RDATA_OUT == {7'h00, !SECURED_OUT};
   endproperty
   a_opt: assert property (p_opt) else $error("option readback");
   property p_dbg;
      SECURED_OUT && !DEBUG_PIN_ENABLE_OUT |-> DEBUG_BLOCKED_OUT;
   endproperty
   a_dbg: assert property (p_dbg) else $error("debug not blocked");
   property p_hv;
      $rose(HIGH_VOLTAGE_ENABLE_OUT)
         |-> $past(PROGRAM_SELECT_OUT) || $past(MASS_ERASE_SELECT_OUT);
   endproperty
   a_hv: assert property (p_hv) else $error("high voltage alone");
   property p_mass;
      CE_IN && WR_IN && !DEBUG_IN && ADDR_IN == `FSCP_FLASH_PROGRAM_ERASE_CONTROL_OFS
         && WDATA_IN == 8'h04 && !PROGRAM_SELECT_OUT
         |=> MASS_ERASE_SELECT_OUT;
   endproperty
   a_mass: assert property (p_mass) else $error("mass not set");
   property p_cfl;
      !(PROGRAM_SELECT_OUT && MASS_ERASE_SELECT_OUT);
   endproperty
   a_cfl: assert property (p_cfl) else $error("both selects set");
   property p_pgm;
      $rose(PROGRAM_SELECT_OUT) |-> !$past(SECURED_OUT);
   endproperty
   a_pgm: assert property (p_pgm) else $error("program while secured");
   property p_sec;
      up_q && $past(up_q) |-> $stable(SECURED_OUT);
   endproperty
   a_sec: assert property (p_sec) else $error("security moved");
   property p_wr;
      SECURED_OUT && DEBUG_BLOCKED_OUT && DEBUG_IN |-> !MEM_WR_OUT;
   endproperty
   a_wr: assert property (p_wr) else $error("refused write leaked");
endmodule : fscp_top_asserts
bind fscp_top fscp_top_asserts u_fscp_top_asserts (.*);
`default_nettype wire

// [testbench/fscp_top_tb.sv]
// Self-checking bench for the flash security, control and paging block.
// Assumes the memory model returns address low byte xor 3C.
`timescale 1ns/100ps
`default_nettype none
`include "fscp_map.svh"
`define CHK(g, e) \
   begin \
      n_compared++; \
      if ((g) !== (e)) \
      begin \
         failures++; \
         $display("mismatch at %0t: got %h want %h", $time, g, e); \
      end \
   end
module fscp_top_tb;
   import fscp_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, dbg = 1'b0;
   logic ms = 1'b1, mem_rd, pin_en, dbg_blk, secured, hv, mass, program_select;
   logic ce = 1'b1;
   logic [13:0] addr = 14'h0000, mem_addr;
   logic [7:0] wdata = 8'h00, nv = 8'hFF, rdata, mem_rdata;
   int failures = 0, n_compared = 0;
   fscp_top u_fscp_top
   (
      .CLK_IN(clk),
      .RST_N_IN(rst_n),
      .CE_IN(ce),
      .MODE_SELECT_PIN_IN(ms),
      .ADDR_IN(addr),
      .WDATA_IN(wdata),
      .WR_IN(wr),
      .RD_IN(rd),
      .DEBUG_IN(dbg),
      .FLASH_OPTION_NONVOLATILE_DATA_IN(nv),
      .MEM_RDATA_IN(mem_rdata),
      .RDATA_OUT(rdata),
      .MEM_ADDR_OUT(mem_addr),
      .MEM_WR_OUT(),
      .MEM_RD_OUT(mem_rd),
      .DEBUG_PIN_ENABLE_OUT(pin_en),
      .DEBUG_BLOCKED_OUT(dbg_blk),
      .SECURED_OUT(secured),
      .HIGH_VOLTAGE_ENABLE_OUT(hv),
      .MASS_ERASE_SELECT_OUT(mass),
      .PROGRAM_SELECT_OUT(program_select),
      .ACCESS_BLOCKED_OUT()
   );
   fscp_mem_model u_fscp_mem_model
   (
      .clk_in(clk),
      .addr_in(mem_addr),
      .rd_in(mem_rd),
      .rdata_out(mem_rdata)
   );
   task automatic conclude();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude
   task automatic do_reset(input logic [7:0] nv_v, input logic ms_v);
      rst_n <= 1'b0;
      nv <= nv_v;
      ms <= ms_v;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : do_reset
   task automatic wr_reg(input logic [13:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : wr_reg
   task automatic rd_chk(input logic [13:0] a, input logic d_v,
                         input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      dbg <= d_v;
      @(posedge clk);
      rd <= 1'b0;
      dbg <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask : rd_chk
   task automatic t_locked();
      do_reset(8'hFE, 1'b1);
      `CHK({secured, dbg_blk, pin_en}, 3'b110)
      rd_chk(`FSCP_FLASH_OPTION_WORKING_OFS, 1'b0, 8'h00);
      wr_reg(`FSCP_FLASH_PROGRAM_ERASE_CONTROL_OFS, 8'h01);
      `CHK(program_select, 1'b0)
      wr_reg(`FSCP_PAGING_WINDOW_SELECTOR_OFS, 8'h80);
      rd_chk(14'h00C3, 1'b0, 8'h3F);
      rd_chk(14'h00C3, 1'b1, 8'h00);
      rd_chk(14'h0055, 1'b0, 8'h69);
   endtask : t_locked
   task automatic t_bdm();
      do_reset(8'hFE, 1'b0);
      `CHK({secured, dbg_blk, pin_en}, 3'b101)
      wr_reg(`FSCP_PAGING_WINDOW_SELECTOR_OFS, 8'h80);
      rd_chk(14'h00C7, 1'b0, 8'h00);
      rd_chk(14'h0055, 1'b1, 8'h69);
      rd_chk(`FSCP_PAGING_WINDOW_SELECTOR_OFS, 1'b1, 8'h80);
   endtask : t_bdm
   task automatic t_open();
      do_reset(8'hFF, 1'b1);
      `CHK({program_select, mass, hv, secured}, 4'h0)
      rd_chk(`FSCP_FLASH_OPTION_WORKING_OFS, 1'b0, 8'h01);
      wr_reg(`FSCP_FLASH_OPTION_WORKING_OFS, 8'hFE);
      rd_chk(`FSCP_FLASH_OPTION_WORKING_OFS, 1'b1, 8'h01);
      wr_reg(`FSCP_PAGING_WINDOW_SELECTOR_OFS, 8'h80);
      rd_chk(`FSCP_PAGING_WINDOW_SELECTOR_OFS, 1'b0, 8'h80);
      rd_chk(14'h00C5, 1'b1, 8'h39);
      wr_reg(`FSCP_PAGING_WINDOW_SELECTOR_OFS, 8'h08);
      rd_chk(14'h00C1, 1'b0, 8'h3D);
      wr_reg(`FSCP_PAGING_WINDOW_SELECTOR_OFS, 8'h0A);
      rd_chk(14'h00FF, 1'b0, 8'h00);
      wr_reg(`FSCP_PAGING_WINDOW_SELECTOR_OFS, 8'h00);
      rd_chk(14'h00D5, 1'b0, 8'h29);
      wr_reg(`FSCP_FLASH_PROGRAM_ERASE_CONTROL_OFS, 8'h08);
      rd_chk(`FSCP_FLASH_PROGRAM_ERASE_CONTROL_OFS, 1'b0, 8'h00);
      wr_reg(`FSCP_FLASH_PROGRAM_ERASE_CONTROL_OFS, 8'h05);
      rd_chk(`FSCP_FLASH_PROGRAM_ERASE_CONTROL_OFS, 1'b0, 8'h00);
      wr_reg(`FSCP_FLASH_PROGRAM_ERASE_CONTROL_OFS, 8'h01);
      rd_chk(`FSCP_FLASH_PROGRAM_ERASE_CONTROL_OFS, 1'b0, 8'h01);
      wr_reg(`FSCP_FLASH_PROGRAM_ERASE_CONTROL_OFS, 8'h05);
      rd_chk(`FSCP_FLASH_PROGRAM_ERASE_CONTROL_OFS, 1'b0, 8'h01);
      wr_reg(`FSCP_FLASH_PROGRAM_ERASE_CONTROL_OFS, 8'h00);
      // Erase order: select, window write, high voltage, deselect
      wr_reg(`FSCP_PAGING_WINDOW_SELECTOR_OFS, 8'h80);
      wr_reg(`FSCP_FLASH_PROGRAM_ERASE_CONTROL_OFS, 8'h04);
      `CHK(mass, 1'b1)
      wr_reg(14'h00C0, 8'h00);
      wr_reg(`FSCP_FLASH_PROGRAM_ERASE_CONTROL_OFS, 8'h0C);
      `CHK(hv, 1'b1)
      wr_reg(`FSCP_FLASH_PROGRAM_ERASE_CONTROL_OFS, 8'h08);
      rd_chk(`FSCP_FLASH_PROGRAM_ERASE_CONTROL_OFS, 1'b0, 8'h08);
      wr_reg(`FSCP_FLASH_PROGRAM_ERASE_CONTROL_OFS, 8'h00);
      // Row program: select, one-byte flash write at C0, high voltage, deselect
      wr_reg(`FSCP_FLASH_PROGRAM_ERASE_CONTROL_OFS, 8'h01);
      wr_reg(14'h00C0, 8'hA5);
      wr_reg(`FSCP_FLASH_PROGRAM_ERASE_CONTROL_OFS, 8'h09);
      `CHK({hv, program_select}, 2'b11)
      wr_reg(`FSCP_FLASH_PROGRAM_ERASE_CONTROL_OFS, 8'h08);
      wr_reg(`FSCP_FLASH_PROGRAM_ERASE_CONTROL_OFS, 8'h00);
      // Frozen clock enable must drop the write
      ce <= 1'b0;
      wr_reg(`FSCP_PAGING_WINDOW_SELECTOR_OFS, 8'h55);
      ce <= 1'b1;
      rd_chk(`FSCP_PAGING_WINDOW_SELECTOR_OFS, 1'b0, 8'h80);
      nv <= 8'hFE;
      repeat (4) @(posedge clk);
      #1;
      `CHK(secured, 1'b0)
      do_reset(8'hFE, 1'b1);
      `CHK(secured, 1'b1)
   endtask : t_open
   initial
   begin
      forever #5 clk = ~clk;
   end
   initial
   begin
      #50000;
      failures++;
      conclude();
   end
   initial
   begin
      t_locked();
      t_bdm();
      t_open();
      conclude();
   end
endmodule : fscp_top_tb
`default_nettype wire
